// *** clkgen_pkg.sv ***
package clkgen_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL_ONE   = 8'h00;
	localparam logic [7:0] OFF_CTRL_TWO   = 8'h04;
	localparam logic [7:0] OFF_STAT_ONE   = 8'h08;
	localparam logic [7:0] OFF_STAT_TWO   = 8'h0c;
	localparam logic [7:0] OFF_FILTER     = 8'h10;
	localparam logic [7:0] OFF_TRIM       = 8'h14;
	localparam logic [7:0] OFF_IRQ_MASK   = 8'h18;

	// Control one fields
	localparam int CTL1_GAIN_BIT   = 7;
	localparam int CTL1_RANGE_BIT  = 6;
	localparam int CTL1_REFSEL_BIT = 5;
	localparam int CTL1_MODE_HI    = 4;
	localparam int CTL1_MODE_LO    = 3;
	localparam logic [7:0] CTL1_WMASK = 8'hfe;
	localparam logic [7:0] CTL1_RESET = 8'h00;

	// Control two fields
	localparam int CTL2_LOLRST_BIT = 7;
	localparam int CTL2_MUL_HI     = 6;
	localparam int CTL2_MUL_LO     = 4;
	localparam int CTL2_LOCRST_BIT = 3;
	localparam int CTL2_DIV_HI     = 2;
	localparam int CTL2_DIV_LO     = 0;
	localparam logic [7:0] CTL2_RESET = 8'h00;

	// Status one fields: sticky events (write one to clear), live mode and lock
	localparam int ST1_LOCK_LOSS_BIT  = 0;
	localparam int ST1_CLOCK_LOSS_BIT = 1;
	localparam int ST1_MODE_LO        = 2;
	localparam int ST1_MODE_HI        = 3;
	localparam int ST1_LOCK_BIT       = 4;
	localparam logic [1:0] EVENT_MASK_W = 2'h3;

	// Status two fields
	localparam int ST2_STABLE_BIT = 0;

	localparam logic [15:0] FILTER_USED   = 16'h0fff;
	localparam logic [11:0] FILTER_RESET  = 12'h800;
	localparam logic [7:0]  TRIM_RESET    = 8'h80;

	// Mode encodings
	localparam logic [1:0] MODE_SELF = 2'h0;
	localparam logic [1:0] MODE_BYP_EXT = 2'h2;
	localparam logic [1:0] MODE_FLL_INT = 2'h1;
	localparam logic [1:0] MODE_FLL_EXT = 2'h3;

	// Prescale factors and internal reference divider
	localparam logic [6:0] PRESCALE_LOW  = 7'h40;
	localparam logic [6:0] PRESCALE_HIGH = 7'h01;
	localparam logic [3:0] INT_REF_DIV   = 4'h7;

	// Timing
	localparam int CLK_HZ          = 50_000_000;
	localparam int MODE_DELAY_NS   = 200;
	localparam int MODE_DELAY_CYC  = (MODE_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int SETTLE_US       = 20;
	localparam int SETTLE_CYC      = SETTLE_US * (CLK_HZ / 1_000_000);
	localparam int LOCK_TOL        = 2;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		WR_IDLE = 3'b001,
		WR_RESP = 3'b010,
		WR_HOLD = 3'b100
	} wr_state_t;

	// Multiplication factor N = 4 + 2*code
	function automatic logic [4:0] mul_factor(input logic [2:0] code);
		return 5'(5'h4 + {code, 1'b0});
	endfunction

	// Division factor R = 2^code
	function automatic logic [7:0] div_factor(input logic [2:0] code);
		return 8'(8'h01 << code);
	endfunction

endpackage

// *** clock_generator.sv ***
// Contract
// [RQ1] Out of reset the generator is self-clocked, about 8 MHz out, 4 MHz bus.
// [RQ2] Control one bit 6 picks range: clear prescale 64, set prescale 1.
// [RQ3] Control one bits 4:3 pick mode: 11 engaged external, 01 engaged internal.
// [RQ4] Control one bit 5 requests crystal; ignored in engaged internal mode.
// [RQ5] Control one bit 7 picks oscillator gain; clear means low power.
// [RQ6] Control one bit 0 is unimplemented and reads zero.
// [RQ7] With bit 7 of control two clear, lock loss raises an interrupt.
// [RQ8] With bit 3 of control two clear, clock loss raises an interrupt.
// [RQ9] Control two bits 6:4 give multiplier N; 000 is 4, 011 is 10.
// [RQ10] Control two bits 2:0 give post divider R; 000 is 1, 001 is 2.
// [RQ11] Status one is read only except a write clears its interrupt flag; the code clears only the event flags written with one.
// [RQ12] Software waits for the oscillator stable bit before time critical work.
// [RQ13] Engaged modes let the loop adjust the 12-bit filter; bits 15:12 read zero.
// [RQ14] Trim register is written only when trimming the internal reference.
// [RQ15] Engaged internal output equals reference/7 times prescale times N over R.
// [RQ16] Engaged external output equals reference times prescale times N over R.
// [RQ17] Near maximum speed software trims with doubled R, then restores it.
// [RQ18] The mode status follows the mode select only after several cycles.
// [RQ19] Oscillator stable asserts only after the selected path has settled.
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
module clock_generator
	import clkgen_pkg::*;
#(
	parameter int SETTLE_CYCLES = SETTLE_CYC,
	parameter int TARGET_W      = 24
) (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic                ext_ref_pin,
	input  wire logic                int_ref_pin,
	input  wire logic                dco_pin,
	input  wire logic                ext_clock_lost,
	output logic [1:0]               clock_mode_status,
	output logic [TARGET_W-1:0]      target_freq_hz,
	output logic [11:0]              dco_filter_out,
	output logic                     oscillator_enable,
	output logic                     high_gain_select,
	output logic                     high_range_select,
	output logic                     lock_loss_reset_req,
	output logic                     clock_loss_reset_req,
	output logic                     irq
);

	// Pin synchronisers
	logic [1:0] ext_sync_r, int_sync_r, dco_sync_r, lost_sync_r;
	logic       ext_prev_r, int_prev_r, dco_prev_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_sync_r  <= 2'h0;
			int_sync_r  <= 2'h0;
			dco_sync_r  <= 2'h0;
			lost_sync_r <= 2'h0;
			ext_prev_r  <= 1'b0;
			int_prev_r  <= 1'b0;
			dco_prev_r  <= 1'b0;
		end else begin
			ext_sync_r  <= {ext_sync_r[0], ext_ref_pin};
			int_sync_r  <= {int_sync_r[0], int_ref_pin};
			dco_sync_r  <= {dco_sync_r[0], dco_pin};
			lost_sync_r <= {lost_sync_r[0], ext_clock_lost};
			ext_prev_r  <= ext_sync_r[1];
			int_prev_r  <= int_sync_r[1];
			dco_prev_r  <= dco_sync_r[1];
		end
	end

	logic ext_rise, int_rise, dco_rise;
	assign ext_rise = ext_sync_r[1] & ~ext_prev_r;
	assign int_rise = int_sync_r[1] & ~int_prev_r;
	assign dco_rise = dco_sync_r[1] & ~dco_prev_r;

	// Registers
	logic [7:0]  ctl1_r, ctl1_nxt, ctl2_r, ctl2_nxt, trim_r, trim_nxt;
	logic [1:0]  evt_r, evt_nxt, mask_r, mask_nxt;
	logic [11:0] filter_r, filter_nxt;
	logic [1:0]  mode_stat_r, mode_stat_nxt;
	logic [7:0]  mode_cnt_r, mode_cnt_nxt;
	logic [15:0] settle_r, settle_nxt;
	logic        stable_r, stable_nxt;
	logic        locked_r, locked_nxt, lost_prev_r, lost_prev_nxt;

	// Write channel
	wr_state_t   wst_r, wst_nxt;
	logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
	logic [7:0]  waddr_r, waddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic        wstrb0_r, wstrb0_nxt, wstrb1_r, wstrb1_nxt;
	logic [1:0]  bresp_nxt;
	logic        bvalid_nxt;
	logic        do_write;

	always_comb begin
		wst_nxt    = wst_r;
		aw_got_nxt = aw_got_r;
		w_got_nxt  = w_got_r;
		waddr_nxt  = waddr_r;
		wdata_nxt  = wdata_r;
		wstrb0_nxt = wstrb0_r;
		wstrb1_nxt = wstrb1_r;
		bresp_nxt  = s_axi_bresp;
		bvalid_nxt = s_axi_bvalid;
		do_write   = 1'b0;
		unique case (wst_r)
			WR_IDLE: begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_got_nxt = 1'b1;
					waddr_nxt  = s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_got_nxt  = 1'b1;
					wdata_nxt  = s_axi_wdata;
					wstrb0_nxt = s_axi_wstrb[0];
					wstrb1_nxt = s_axi_wstrb[1];
				end
				if (aw_got_r && w_got_r) begin
					wst_nxt = WR_RESP;
				end
			end
			WR_RESP: begin
				do_write   = 1'b1;
				bvalid_nxt = 1'b1;
				bresp_nxt  = (waddr_r[7:2] <= OFF_IRQ_MASK[7:2] && waddr_r[1:0] == 2'h0)
					? RESP_OKAY : RESP_SLVERR;
				wst_nxt    = WR_HOLD;
			end
			WR_HOLD: begin
				if (s_axi_bready) begin
					bvalid_nxt = 1'b0;
					aw_got_nxt = 1'b0;
					w_got_nxt  = 1'b0;
					wst_nxt    = WR_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wst_r         <= WR_IDLE;
			aw_got_r      <= 1'b0;
			w_got_r       <= 1'b0;
			waddr_r       <= 8'h00;
			wdata_r       <= 32'h0000_0000;
			wstrb0_r      <= 1'b0;
			wstrb1_r      <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			s_axi_bvalid  <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			wst_r         <= wst_nxt;
			aw_got_r      <= aw_got_nxt;
			w_got_r       <= w_got_nxt;
			waddr_r       <= waddr_nxt;
			wdata_r       <= wdata_nxt;
			wstrb0_r      <= wstrb0_nxt;
			wstrb1_r      <= wstrb1_nxt;
			s_axi_bresp   <= bresp_nxt;
			s_axi_bvalid  <= bvalid_nxt;
			s_axi_awready <= (wst_nxt == WR_IDLE) && !aw_got_nxt;
			s_axi_wready  <= (wst_nxt == WR_IDLE) && !w_got_nxt;
		end
	end

	// Lane decode of the pending write
	logic wr_ctl1, wr_ctl2, wr_st1, wr_flt_lo, wr_flt_hi, wr_trim, wr_mask;
	assign wr_ctl1   = do_write && wstrb0_r && waddr_r == OFF_CTRL_ONE;
	assign wr_ctl2   = do_write && wstrb0_r && waddr_r == OFF_CTRL_TWO;
	assign wr_st1    = do_write && wstrb0_r && waddr_r == OFF_STAT_ONE;
	assign wr_flt_lo = do_write && wstrb0_r && waddr_r == OFF_FILTER;
	assign wr_flt_hi = do_write && wstrb1_r && waddr_r == OFF_FILTER;
	assign wr_trim   = do_write && wstrb0_r && waddr_r == OFF_TRIM;
	assign wr_mask   = do_write && wstrb0_r && waddr_r == OFF_IRQ_MASK;

	// Frequency model
	logic [1:0]  mode_sel;
	logic [6:0]  prescale;
	logic [4:0]  n_fac;
	logic [7:0]  r_fac;
	logic        engaged;
	logic [31:0] ref_hz;
	logic [TARGET_W-1:0] target_nxt;
	logic [15:0] meas_cnt_r, meas_cnt_nxt, dco_cnt_r, dco_cnt_nxt;
	logic [15:0] want_cnt;

	assign mode_sel = ctl1_r[CTL1_MODE_HI:CTL1_MODE_LO];                        // RQ3
	assign prescale = ctl1_r[CTL1_RANGE_BIT] ? PRESCALE_HIGH : PRESCALE_LOW;    // RQ2
	assign n_fac    = mul_factor(ctl2_r[CTL2_MUL_HI:CTL2_MUL_LO]);              // RQ9
	assign r_fac    = div_factor(ctl2_r[CTL2_DIV_HI:CTL2_DIV_LO]);              // RQ10
	assign engaged  = mode_stat_r[0];

	always_comb begin
		ref_hz = 32'h0;
		unique case (mode_stat_r)
			MODE_FLL_INT: ref_hz = 32'd243_000 / 32'(INT_REF_DIV);            // RQ15
			MODE_FLL_EXT: ref_hz = 32'd4_000_000;                             // RQ16
			default:      ref_hz = 32'd8_000_000;                             // RQ1
		endcase
		if (engaged) begin
			target_nxt = TARGET_W'(ref_hz * 32'(prescale) * 32'(n_fac) / 32'(r_fac)); // RQ15 RQ16
		end else begin
			target_nxt = TARGET_W'(ref_hz / 32'(r_fac));
		end
		// Loop counts DCO edges per reference edge and steers the filter toward N*P
		want_cnt = 16'(16'(prescale) * 16'(n_fac));
	end

	// Mode status, settling, loop and event logic
	always_comb begin
		ctl1_nxt      = ctl1_r;
		ctl2_nxt      = ctl2_r;
		trim_nxt      = trim_r;
		mask_nxt      = mask_r;
		filter_nxt    = filter_r;
		mode_stat_nxt = mode_stat_r;
		mode_cnt_nxt  = mode_cnt_r;
		settle_nxt    = settle_r;
		stable_nxt    = stable_r;
		locked_nxt    = locked_r;
		meas_cnt_nxt  = meas_cnt_r;
		dco_cnt_nxt   = dco_cnt_r;
		lost_prev_nxt = lost_sync_r[1];
		evt_nxt       = evt_r;

		if (wr_ctl1) ctl1_nxt = wdata_r[7:0] & CTL1_WMASK;                  // RQ6
		if (wr_ctl2) ctl2_nxt = wdata_r[7:0];
		if (wr_trim) trim_nxt = wdata_r[7:0];                                // RQ14
		if (wr_mask) mask_nxt = wdata_r[1:0] & EVENT_MASK_W;
		if (!engaged && wr_flt_lo) filter_nxt[7:0] = wdata_r[7:0];
		if (!engaged && wr_flt_hi) filter_nxt[11:8] = wdata_r[11:8];
		if (wr_st1) evt_nxt = evt_r & ~wdata_r[1:0];                         // RQ11

		if (!stable_r) begin
			if (settle_r == 16'(SETTLE_CYCLES)) begin
				stable_nxt = 1'b1;                                               // RQ19
			end else begin
				settle_nxt = 16'(settle_r + 16'h1);
			end
		end

		// Mode status trails the select by a fixed delay
		if (mode_sel != mode_stat_r) begin
			if (mode_cnt_r == 8'(MODE_DELAY_CYC)) begin
				mode_stat_nxt = mode_sel;                                        // RQ18
				mode_cnt_nxt  = 8'h00;
				settle_nxt    = 16'h0;
				stable_nxt    = 1'b0;
				locked_nxt    = 1'b0;
			end else begin
				mode_cnt_nxt = 8'(mode_cnt_r + 8'h01);
			end
		end else begin
			mode_cnt_nxt = 8'h00;
		end

		// Frequency lock loop on measured edges
		if (dco_rise) dco_cnt_nxt = 16'(dco_cnt_r + 16'h1);
		if (engaged && (mode_stat_r == MODE_FLL_INT ? int_rise : ext_rise)) begin
			if (dco_cnt_r < want_cnt - 16'(LOCK_TOL)) begin
				if (filter_r != 12'hfff) filter_nxt = 12'(filter_r + 12'h1);    // RQ13
				locked_nxt = 1'b0;
			end else if (dco_cnt_r > want_cnt + 16'(LOCK_TOL)) begin
				if (filter_r != 12'h000) filter_nxt = 12'(filter_r - 12'h1);    // RQ13
				locked_nxt = 1'b0;
			end else begin
				locked_nxt = 1'b1;
			end
			dco_cnt_nxt  = 16'h0;
			meas_cnt_nxt = 16'(meas_cnt_r + 16'h1);
		end

		// Sticky events; set wins over clear
		if (locked_r && !locked_nxt && engaged && !ctl2_r[CTL2_LOLRST_BIT]) begin
			evt_nxt[ST1_LOCK_LOSS_BIT] = 1'b1;                                   // RQ7
		end
		if (lost_sync_r[1] && !lost_prev_r && mode_stat_r[1]
			&& !ctl2_r[CTL2_LOCRST_BIT]) begin
			evt_nxt[ST1_CLOCK_LOSS_BIT] = 1'b1;                                  // RQ8
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl1_r               <= CTL1_RESET;
			ctl2_r               <= CTL2_RESET;
			trim_r               <= TRIM_RESET;
			mask_r               <= 2'h0;
			evt_r                <= 2'h0;
			filter_r             <= FILTER_RESET;
			mode_stat_r          <= MODE_SELF;                                   // RQ1
			mode_cnt_r           <= 8'h00;
			settle_r             <= 16'h0;
			stable_r             <= 1'b0;
			locked_r             <= 1'b0;
			lost_prev_r          <= 1'b0;
			meas_cnt_r           <= 16'h0;
			dco_cnt_r            <= 16'h0;
			clock_mode_status    <= MODE_SELF;
			target_freq_hz       <= '0;
			dco_filter_out       <= FILTER_RESET;
			oscillator_enable    <= 1'b0;
			high_gain_select     <= 1'b0;
			high_range_select    <= 1'b0;
			lock_loss_reset_req  <= 1'b0;
			clock_loss_reset_req <= 1'b0;
			irq                  <= 1'b0;
		end else begin
			ctl1_r               <= ctl1_nxt;
			ctl2_r               <= ctl2_nxt;
			trim_r               <= trim_nxt;
			mask_r               <= mask_nxt;
			evt_r                <= evt_nxt;
			filter_r             <= filter_nxt;
			mode_stat_r          <= mode_stat_nxt;
			mode_cnt_r           <= mode_cnt_nxt;
			settle_r             <= settle_nxt;
			stable_r             <= stable_nxt;
			locked_r             <= locked_nxt;
			lost_prev_r          <= lost_prev_nxt;
			meas_cnt_r           <= meas_cnt_nxt;
			dco_cnt_r            <= dco_cnt_nxt;
			clock_mode_status    <= mode_stat_nxt;
			target_freq_hz       <= target_nxt;
			dco_filter_out       <= filter_nxt;
			oscillator_enable    <= ctl1_nxt[CTL1_REFSEL_BIT]
				&& mode_sel != MODE_FLL_INT;                                     // RQ4
			high_gain_select     <= ctl1_nxt[CTL1_GAIN_BIT];                      // RQ5
			high_range_select    <= ctl1_nxt[CTL1_RANGE_BIT];
			lock_loss_reset_req  <= locked_r && !locked_nxt && engaged
				&& ctl2_r[CTL2_LOLRST_BIT];
			clock_loss_reset_req <= lost_sync_r[1] && !lost_prev_r && mode_stat_r[1]
				&& ctl2_r[CTL2_LOCRST_BIT];
			irq                  <= |(evt_nxt & mask_nxt);
		end
	end

	// Read channel
	logic [31:0] rdata_nxt;
	logic [1:0]  rresp_nxt;
	logic        rvalid_nxt, arready_nxt;

	always_comb begin
		rdata_nxt   = s_axi_rdata;
		rresp_nxt   = s_axi_rresp;
		rvalid_nxt  = s_axi_rvalid;
		arready_nxt = s_axi_arready;
		if (s_axi_rvalid && s_axi_rready) begin
			rvalid_nxt  = 1'b0;
			arready_nxt = 1'b1;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt  = 1'b1;
			arready_nxt = 1'b0;
			rresp_nxt   = RESP_OKAY;
			rdata_nxt   = 32'h0;
			unique case (s_axi_araddr)
				OFF_CTRL_ONE: rdata_nxt[7:0] = ctl1_r;                           // RQ6
				OFF_CTRL_TWO: rdata_nxt[7:0] = ctl2_r;
				OFF_STAT_ONE: rdata_nxt[7:0] = {3'h0, locked_r, mode_stat_r, evt_r};
				OFF_STAT_TWO: rdata_nxt[ST2_STABLE_BIT] = stable_r;              // RQ12
				OFF_FILTER:   rdata_nxt[15:0] = {4'h0, filter_r} & FILTER_USED;  // RQ13
				OFF_TRIM:     rdata_nxt[7:0] = trim_r;
				OFF_IRQ_MASK: rdata_nxt[1:0] = mask_r;
				default:      rresp_nxt = RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= RESP_OKAY;
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end else begin
			s_axi_rdata   <= rdata_nxt;
			s_axi_rresp   <= rresp_nxt;
			s_axi_rvalid  <= rvalid_nxt;
			s_axi_arready <= arready_nxt;
		end
	end

endmodule

// *** clkgen_asserts.sv ***
module clkgen_asserts
	import clkgen_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic [1:0]  clock_mode_status,
	input wire logic        oscillator_enable,
	input wire logic        high_gain_select,
	input wire logic        high_range_select,
	input wire logic        lock_loss_reset_req,
	input wire logic        clock_loss_reset_req
);
	logic [7:0] aw_r;
	logic [7:0] ar_r;
	logic [7:0] wd_r;
	logic [7:0] c1_r;
	logic [7:0] c2_r;
	logic       wr1;

	// Shadow copies of both control registers, taken at the write response
	assign wr1 = s_axi_bvalid && s_axi_bready && aw_r == OFF_CTRL_ONE;

	always_ff @(posedge aclk) begin
		if (s_axi_awvalid && s_axi_awready) aw_r <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata[7:0];
		if (s_axi_arvalid && s_axi_arready) ar_r <= s_axi_araddr;
		if (!aresetn) begin
			c1_r <= CTL1_RESET;
			c2_r <= CTL2_RESET;
		end else if (s_axi_bvalid && s_axi_bready) begin
			if (aw_r == OFF_CTRL_ONE) c1_r <= wd_r;
			if (aw_r == OFF_CTRL_TWO) c2_r <= wd_r;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_mode_lands;
		##[1:40] clock_mode_status == c1_r[CTL1_MODE_HI:CTL1_MODE_LO];
	endsequence

	property p_gain; wr1 |-> ##2 high_gain_select == c1_r[CTL1_GAIN_BIT]; endproperty
	property p_range; wr1 |-> ##2 high_range_select == c1_r[CTL1_RANGE_BIT]; endproperty
	property p_osc;
		wr1 |-> ##2 oscillator_enable == (c1_r[CTL1_REFSEL_BIT] && c1_r[4:3] != MODE_FLL_INT);
	endproperty
	property p_hold; wr1 |-> $stable(clock_mode_status) [*3]; endproperty
	property p_mode; wr1 |-> s_mode_lands; endproperty
	property p_lol; !c2_r[CTL2_LOLRST_BIT] |-> !lock_loss_reset_req; endproperty
	property p_loc; !c2_r[CTL2_LOCRST_BIT] |-> !clock_loss_reset_req; endproperty
	property p_bit0; s_axi_rvalid && ar_r == OFF_CTRL_ONE |-> s_axi_rdata[0] == 1'b0; endproperty
	property p_filt; s_axi_rvalid && ar_r == OFF_FILTER |-> s_axi_rdata[15:12] == 4'h0; endproperty

	a_gain: assert property (p_gain) else $error("gain select wrong");
	a_range: assert property (p_range) else $error("range select wrong");
	a_osc: assert property (p_osc) else $error("oscillator enable wrong");
	a_hold: assert property (p_hold) else $error("mode status moved early");
	a_mode: assert property (p_mode) else $error("mode status never followed");
	a_lol: assert property (p_lol) else $error("lock loss gave reset");
	a_loc: assert property (p_loc) else $error("clock loss gave reset");
	a_bit0: assert property (p_bit0) else $error("control one bit 0 set");
	a_filt: assert property (p_filt) else $error("filter upper bits set");
endmodule

bind clock_generator clkgen_asserts clkgen_asserts_i (.*);

// *** ref_source.sv ***
module ref_source (
	input  wire logic aclk,
	input  wire logic oscillator_enable,
	input  wire logic cut,
	output logic      ext_ref_pin,
	output logic      int_ref_pin,
	output logic      dco_pin,
	output logic      ext_clock_lost
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] cnt_r = 3'h0;

	initial begin
		ext_ref_pin = 1'b0;
		int_ref_pin = 1'b0;
		dco_pin = 1'b0;
		ext_clock_lost = 1'b0;
	end

	// Crystal stands still while disabled or cut
	always @(posedge aclk) begin
		cnt_r <= cnt_r + 3'h1;
		dco_pin <= ~dco_pin;
		ext_clock_lost <= cut;
		if (cnt_r == 3'h0)
			int_ref_pin <= ~int_ref_pin;
		if (cnt_r[0] && oscillator_enable && !cut)
			ext_ref_pin <= ~ext_ref_pin;
	end
endmodule

// *** tb_clock_generator.sv ***
module tb_clock_generator
	import clkgen_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        aclk = 1'b0;
	logic        aresetn;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, target_freq_hz, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, clock_mode_status, resp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, ext_ref_pin, int_ref_pin, dco_pin;
	logic        ext_clock_lost, cut, oscillator_enable, high_gain_select;
	logic        high_range_select, lock_loss_reset_req, clock_loss_reset_req, irq;
	logic [11:0] dco_filter_out;
	int          miscompares = 0;
	int          checked = 0;
	int          cycles = 0;
	int          n_loc = 0;

	clock_generator #(.SETTLE_CYCLES(20), .TARGET_W(32)) clock_generator_i (.*);
	ref_source ref_source_i (.*);

	always #10 aclk = ~aclk;

	task automatic close_out();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	always @(posedge aclk) begin
		cycles++;
		if (clock_loss_reset_req === 1'b1)
			n_loc++;
		if (cycles == 6000) begin
			miscompares++;
			close_out();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] e);
		checked++;
		if (got !== e) begin
			miscompares++;
			$display("ERROR %0t got %h expected %h", $time, got, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		resp = s_axi_bresp;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		v = s_axi_rdata;
		resp = s_axi_rresp;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		rd(a, d);
		check(d, e);
	endtask

	task automatic near(input logic [31:0] e, input logic [31:0] t);
		for (int i = 0; i < 20 && !(target_freq_hz >= e - t && target_freq_hz <= e + t); i++)
			@(posedge aclk);
		check(32'(target_freq_hz >= e - t && target_freq_hz <= e + t), 32'h1);
	endtask

	task automatic irq_is(input logic v);
		for (int i = 0; i < 20 && irq !== v; i++)
			@(posedge aclk);
		check(32'(irq), 32'(v));
	endtask

	task automatic settle(input logic [1:0] m, input logic fresh);
		for (int i = 0; i < 60 && clock_mode_status !== m; i++)
			@(posedge aclk);
		check(32'(clock_mode_status), 32'(m));
		rd(OFF_STAT_TWO, d);
		if (fresh)
			check(32'(d[ST2_STABLE_BIT]), 32'h0);
		while (d[ST2_STABLE_BIT] !== 1'b1)
			rd(OFF_STAT_TWO, d);
	endtask

	initial begin
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, cut} = '0;
		s_axi_wstrb = 4'hf;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		check(32'(clock_mode_status), 32'(MODE_SELF));
		near(32'd8_000_000, 32'd400_000);
		rchk(OFF_CTRL_ONE, 32'(CTL1_RESET));
		rchk(OFF_CTRL_TWO, 32'(CTL2_RESET));
		rchk(OFF_IRQ_MASK, 32'h0);
		rchk(OFF_FILTER, 32'(FILTER_RESET));
		rchk(OFF_TRIM, 32'(TRIM_RESET));
		rchk(8'h1c, 32'h0);
		check(32'(resp), 32'(RESP_SLVERR));
		wr(8'h40, 32'h1);
		check(32'(resp), 32'(RESP_SLVERR));
		wr(OFF_CTRL_ONE, 32'hc1);
		rchk(OFF_CTRL_ONE, 32'hc0);
		check(32'(high_range_select), 32'h1);
		check(32'(high_gain_select), 32'h1);
		wr(OFF_FILTER, 32'hffff);
		rchk(OFF_FILTER, 32'h0fff);
		check(32'(dco_filter_out), 32'h0fff);
		wr(OFF_TRIM, 32'h5a);
		rchk(OFF_TRIM, 32'h5a);
		wr(OFF_TRIM, 32'(TRIM_RESET));
		wr(OFF_CTRL_TWO, 32'h30);
		wr(OFF_CTRL_ONE, 32'h78);
		check(32'(clock_mode_status), 32'(MODE_SELF));
		settle(MODE_FLL_EXT, 1'b1);
		rd(OFF_STAT_ONE, d);
		check(32'(d[ST1_MODE_HI:ST1_MODE_LO]), 32'(MODE_FLL_EXT));
		check(32'(oscillator_enable), 32'h1);
		near(32'd40_000_000, 32'd0);
		for (int c = 0; c < 8; c++) begin
			wr(OFF_CTRL_TWO, 32'(c << 4));
			near(32'(4_000_000 * (4 + 2 * c)), 32'd0);
			wr(OFF_CTRL_TWO, 32'(c));
			near(32'(16_000_000 >> c), 32'd0);
		end
		rd(OFF_STAT_ONE, d);
		check(32'(d[ST1_LOCK_LOSS_BIT]), 32'h1);
		wr(OFF_CTRL_TWO, 32'h0);
		wr(OFF_CTRL_ONE, 32'h38);
		near(32'd1_024_000_000, 32'd0);
		check(32'(high_range_select), 32'h0);
		wr(OFF_CTRL_TWO, 32'h31);
		wr(OFF_CTRL_ONE, 32'h28);
		settle(MODE_FLL_INT, 1'b1);
		check(32'(oscillator_enable), 32'h0);
		near(32'd11_108_571, 32'd500_000);
		wr(OFF_CTRL_TWO, 32'h32);
		near(32'd5_554_286, 32'd250_000);
		wr(OFF_TRIM, 32'(TRIM_RESET));
		wr(OFF_CTRL_TWO, 32'h31);
		near(32'd11_108_571, 32'd500_000);
		wr(OFF_CTRL_TWO, 32'h38);
		wr(OFF_CTRL_ONE, 32'h78);
		settle(MODE_FLL_EXT, 1'b1);
		cut <= 1'b1;
		for (int i = 0; i < 20 && n_loc == 0; i++)
			@(posedge aclk);
		check(32'(n_loc), 32'h1);
		rd(OFF_STAT_ONE, d);
		check(32'(d[ST1_CLOCK_LOSS_BIT]), 32'h0);
		cut <= 1'b0;
		wr(OFF_CTRL_TWO, 32'h30);
		wr(OFF_CTRL_ONE, 32'h0);
		settle(MODE_SELF, 1'b0);
		wr(OFF_CTRL_ONE, 32'h78);
		settle(MODE_FLL_EXT, 1'b1);
		wr(OFF_IRQ_MASK, 32'h2);
		cut <= 1'b1;
		irq_is(1'b1);
		wr(OFF_STAT_ONE, 32'h1c);
		rd(OFF_STAT_ONE, d);
		check(32'(d[ST1_CLOCK_LOSS_BIT]), 32'h1);
		check(32'(d[ST1_MODE_HI:ST1_MODE_LO]), 32'(MODE_FLL_EXT));
		wr(OFF_IRQ_MASK, 32'h0);
		irq_is(1'b0);
		wr(OFF_IRQ_MASK, 32'h2);
		irq_is(1'b1);
		cut <= 1'b0;
		wr(OFF_STAT_ONE, 32'h3);
		irq_is(1'b0);
		rd(OFF_STAT_ONE, d);
		check(32'(d[ST1_CLOCK_LOSS_BIT]), 32'h0);
		close_out();
	end
endmodule
